// >>> logic/eeif_top.sv
// external edge interrupt flags: registers, flags and service requests
// Notes on behaviour
// - priority and flag bits 7:5 read zero; writes there change nothing
// - priority bits 4,3,2 set spare B, spare A, frequency counter level
// - spare flags 4,3 set only by software writing one
// - flag 2 set when serializer holding register empties
// - hardware never clears flag 2; software clears before next load
// - edge flags 1,0 set by chosen edge regardless of enable
// - edge sources respond to transitions only, never to levels
// - each source triggers on rising, falling or both edges
// - after inversion detect rising only or both, per mode bit
// - entering or leaving service does not clear edge flags
// - pins sampled on system clock; pulses under one period may miss
// - edge events B and A drive timer 3 and timer 2 capture
// - config bits 7 and 3 invert the pin for B and A
// - config bits 6:4 pick pin for B; code 101 picks pin 9
// - config bits 2:0 pick pin for A; code 101 picks pin 8
// - source A request reaches cpu only when its enable is one
`timescale 1ns/1ps
module eeif_top #(
	parameter int GPIO_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [GPIO_W-1:0] gpio_in,
	input wire logic ser_holding_empty,
	input wire logic service_enter,
	input wire logic service_return,
	output logic timer2_capture,
	output logic timer3_capture,
	output logic ext_edge_a_req,
	output logic ext_edge_a_high,
	output logic ext_edge_b_req,
	output logic ext_edge_b_high,
	output logic ser_empty_req,
	output logic spare_a_req,
	output logic spare_a_high,
	output logic spare_b_req,
	output logic spare_b_high,
	output logic freq_counter_high
);
	logic [7:0] ext_int_pin_config;
	logic [eeif_pkg::FLAG_W-1:0] interrupt_flags;
	logic [4:0] extended_priority;
	logic [6:0] edge_control;
	logic [GPIO_W-1:0] pins_sync;
	logic edge_a;
	logic edge_b;
	logic ser_empty_last;
	logic ser_empty_rise;
	logic wr_en;
	logic rd_en;
	logic hit;
	logic [7:0] rd_byte;
	logic [eeif_pkg::FLAG_W-1:0] hw_set;
	logic [eeif_pkg::FLAG_W-1:0] sw_clear;
	logic [eeif_pkg::FLAG_W-1:0] sw_set;
	logic [eeif_pkg::FLAG_W-1:0] next_flags;

	initial
	begin
		if (GPIO_W != eeif_pkg::GPIO_W)
			$error("eeif_top: GPIO_W must match the pin map");
		if (eeif_pkg::FLAG_W != 5 || eeif_pkg::PIN_ALT_B >= GPIO_W)
			$error("eeif_top: flag width or alternate pin out of range");
	end

	// ----------------------------------------
	// pin sampling and edge detection
	// ----------------------------------------
	eeif_sync #(
		.WIDTH(GPIO_W)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(gpio_in),
		.sync_out(pins_sync)
	);

	eeif_edge #(
		.GPIO_W(GPIO_W),
		.ALT_PIN(eeif_pkg::PIN_ALT_A)
	) u_edge_a (
		.pclk(pclk),
		.presetn(presetn),
		.pins(pins_sync),
		.pin_select(ext_int_pin_config[eeif_pkg::CFG_A_SEL_LO +: 3]),
		.invert(ext_int_pin_config[eeif_pkg::CFG_A_INVERT]),
		.both_edges(edge_control[eeif_pkg::CTL_A_BOTH]),
		.edge_event(edge_a)
	);

	eeif_edge #(
		.GPIO_W(GPIO_W),
		.ALT_PIN(eeif_pkg::PIN_ALT_B)
	) u_edge_b (
		.pclk(pclk),
		.presetn(presetn),
		.pins(pins_sync),
		.pin_select(ext_int_pin_config[eeif_pkg::CFG_B_SEL_LO +: 3]),
		.invert(ext_int_pin_config[eeif_pkg::CFG_B_INVERT]),
		.both_edges(edge_control[eeif_pkg::CTL_B_BOTH]),
		.edge_event(edge_b)
	);

	// serializer empty is a level from the same clock; flag on its rise
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ser_empty_last <= 1'b0;
		else
			ser_empty_last <= ser_holding_empty;
	end

	assign ser_empty_rise = ser_holding_empty & ~ser_empty_last;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// zero wait states: the access phase completes on its first edge
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~pwrite;

	always_comb
	begin
		hit = 1'b1;
		if (paddr == eeif_pkg::ADDR_PIN_CONFIG)
			rd_byte = ext_int_pin_config;
		else if (paddr == eeif_pkg::ADDR_FLAGS)
			rd_byte = {3'h0, interrupt_flags};
		else if (paddr == eeif_pkg::ADDR_PRIORITY)
			rd_byte = {3'h0, extended_priority};
		else if (paddr == eeif_pkg::ADDR_CONTROL)
			rd_byte = {1'b0, edge_control};
		else
		begin
			rd_byte = 8'h00;
			hit = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			// registered answer: ready rises in the access phase, one edge after setup
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
		end
	end

	// read data stands only while ready does, zero otherwise
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en & ~penable)
			prdata <= {24'h00_0000, rd_byte};
		else
			prdata <= 32'h0000_0000;
	end

	logic wr_take;
	assign wr_take = wr_en & pready;

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ext_int_pin_config <= eeif_pkg::RESET_PIN_CONFIG;
		else if (wr_take && paddr == eeif_pkg::ADDR_PIN_CONFIG)
			ext_int_pin_config <= pwdata[7:0];
	end

	// bits 1:0 are kept writable storage but feed nothing
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			extended_priority <= eeif_pkg::RESET_PRIORITY[4:0];
		else if (wr_take && paddr == eeif_pkg::ADDR_PRIORITY)
			extended_priority <= pwdata[4:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			edge_control <= eeif_pkg::RESET_CONTROL[6:0];
		else if (wr_take && paddr == eeif_pkg::ADDR_CONTROL)
			edge_control <= pwdata[6:0];
	end

	// ----------------------------------------
	// sticky flags
	// ----------------------------------------
	// write 1 to a spare flag sets it; write 0 to any flag clears it
	always_comb
	begin
		hw_set = '0;
		hw_set[eeif_pkg::FLAG_EDGE_A] = edge_a;
		hw_set[eeif_pkg::FLAG_EDGE_B] = edge_b;
		hw_set[eeif_pkg::FLAG_SER_EMPTY] = ser_empty_rise;
		sw_set = '0;
		sw_clear = '0;
		if (wr_take && paddr == eeif_pkg::ADDR_FLAGS)
		begin
			sw_clear = ~pwdata[eeif_pkg::FLAG_W-1:0];
			sw_set[eeif_pkg::FLAG_SPARE_A] = pwdata[eeif_pkg::FLAG_SPARE_A];
			sw_set[eeif_pkg::FLAG_SPARE_B] = pwdata[eeif_pkg::FLAG_SPARE_B];
		end
		// set beats clear; service entry and return never clear
		next_flags = (interrupt_flags & ~sw_clear) | sw_set | hw_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			interrupt_flags <= eeif_pkg::RESET_FLAGS[4:0];
		else
			interrupt_flags <= next_flags;
	end

	// ----------------------------------------
	// capture events and requests
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			timer2_capture <= 1'b0;
			timer3_capture <= 1'b0;
		end
		else
		begin
			timer2_capture <= edge_a;
			timer3_capture <= edge_b;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_edge_a_req <= 1'b0;
			ext_edge_b_req <= 1'b0;
			ser_empty_req <= 1'b0;
			spare_a_req <= 1'b0;
			spare_b_req <= 1'b0;
		end
		else
		begin
			ext_edge_a_req <= interrupt_flags[eeif_pkg::FLAG_EDGE_A]
				& edge_control[eeif_pkg::CTL_EN_A];
			ext_edge_b_req <= interrupt_flags[eeif_pkg::FLAG_EDGE_B]
				& edge_control[eeif_pkg::CTL_EN_B];
			ser_empty_req <= interrupt_flags[eeif_pkg::FLAG_SER_EMPTY]
				& edge_control[eeif_pkg::CTL_EN_SER];
			spare_a_req <= interrupt_flags[eeif_pkg::FLAG_SPARE_A]
				& edge_control[eeif_pkg::CTL_EN_SPARE_A];
			spare_b_req <= interrupt_flags[eeif_pkg::FLAG_SPARE_B]
				& edge_control[eeif_pkg::CTL_EN_SPARE_B];
		end
	end

	// priority levels follow their bits whether or not a source is enabled
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_edge_a_high <= 1'b0;
			ext_edge_b_high <= 1'b0;
			spare_a_high <= 1'b0;
			spare_b_high <= 1'b0;
			freq_counter_high <= 1'b0;
		end
		else
		begin
			// edge sources take their priority from outside; not held here
			ext_edge_a_high <= 1'b0;
			ext_edge_b_high <= 1'b0;
			spare_a_high <= extended_priority[eeif_pkg::PRI_SPARE_A];
			spare_b_high <= extended_priority[eeif_pkg::PRI_SPARE_B];
			freq_counter_high <= extended_priority[eeif_pkg::PRI_FREQ];
		end
	end

	// service strobes are accepted only to show they leave flags alone
	logic unused_service;
	assign unused_service = service_enter | service_return;
endmodule

// >>> logic/eeif_pkg.sv
// shared constants for the external edge interrupt flag block
package eeif_pkg;
	localparam int ADDR_W = 12;
	// printed offsets are not word multiples: kept as indices, byte address is four times
	localparam logic [7:0] IDX_PIN_CONFIG = 8'hB7;
	localparam logic [7:0] IDX_FLAGS = 8'hBF;
	localparam logic [7:0] IDX_PRIORITY = 8'hF6;
	localparam logic [11:0] ADDR_PIN_CONFIG = {2'h0, IDX_PIN_CONFIG, 2'h0};
	localparam logic [11:0] ADDR_FLAGS = {2'h0, IDX_FLAGS, 2'h0};
	localparam logic [11:0] ADDR_PRIORITY = {2'h0, IDX_PRIORITY, 2'h0};
	// own control word: edge modes and enables
	localparam logic [11:0] ADDR_CONTROL = 12'h400;
	localparam logic [7:0] RESET_PIN_CONFIG = 8'h00;
	localparam logic [7:0] RESET_FLAGS = 8'h00;
	localparam logic [7:0] RESET_PRIORITY = 8'h00;
	localparam logic [7:0] RESET_CONTROL = 8'h00;
	// priority fields
	localparam int PRI_SPARE_B = 4;
	localparam int PRI_SPARE_A = 3;
	localparam int PRI_FREQ = 2;
	localparam logic [7:0] PRI_WRITE_MASK = 8'h1F;
	// flag fields
	localparam int FLAG_SPARE_B = 4;
	localparam int FLAG_SPARE_A = 3;
	localparam int FLAG_SER_EMPTY = 2;
	localparam int FLAG_EDGE_B = 1;
	localparam int FLAG_EDGE_A = 0;
	localparam int FLAG_W = 5;
	// pin config fields
	localparam int CFG_B_INVERT = 7;
	localparam int CFG_B_SEL_LO = 4;
	localparam int CFG_A_INVERT = 3;
	localparam int CFG_A_SEL_LO = 0;
	// control fields (own register)
	localparam int CTL_A_BOTH = 0;
	localparam int CTL_B_BOTH = 1;
	localparam int CTL_EN_A = 2;
	localparam int CTL_EN_B = 3;
	localparam int CTL_EN_SER = 4;
	localparam int CTL_EN_SPARE_A = 5;
	localparam int CTL_EN_SPARE_B = 6;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h7F;
	// pins picked by code 101
	localparam int PIN_ALT_A = 8;
	localparam int PIN_ALT_B = 9;
	localparam int GPIO_W = 10;
	localparam int SYNC_STAGES = 2;
endpackage

// >>> logic/eeif_sync.sv
// two-flop synchroniser for a pin bus
`timescale 1ns/1ps
module eeif_sync #(
	parameter int WIDTH = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	initial
	begin
		if (WIDTH < 1)
			$error("eeif_sync: WIDTH must be positive");
	end

	// stage1 is read only by the second flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// >>> logic/eeif_edge.sv
// one external source: pin select, invert, edge detect
`timescale 1ns/1ps
module eeif_edge #(
	parameter int GPIO_W = 10,
	parameter int ALT_PIN = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [GPIO_W-1:0] pins,
	input wire logic [2:0] pin_select,
	input wire logic invert,
	input wire logic both_edges,
	output logic edge_event
);
	logic sel_pin;
	logic level;
	logic last_level;
	logic primed;

	initial
	begin
		if (ALT_PIN >= GPIO_W || GPIO_W < 8)
			$error("eeif_edge: pin index out of range");
	end

	always_comb
	begin
		case (pin_select)
			3'h5: sel_pin = pins[ALT_PIN];
			3'h6: sel_pin = pins[6];
			3'h7: sel_pin = pins[7];
			default: sel_pin = pins[pin_select];
		endcase
	end

	assign level = sel_pin ^ invert;

	// primed blocks a false edge from the reset value of last_level
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			last_level <= 1'b0;
			primed <= 1'b0;
		end
		else
		begin
			last_level <= level;
			primed <= 1'b1;
		end
	end

	// only transitions count; a steady level never fires
	always_comb
	begin
		if (!primed)
			edge_event = 1'b0;
		else if (both_edges)
			edge_event = level ^ last_level;
		else
			edge_event = level & ~last_level;
	end
endmodule

// >>> bench/eeif_top_sva.sv
// concurrent checks on the external edge interrupt flag block ports
`timescale 1ns/1ps
module eeif_top_sva #(
	parameter int GPIO_W = 10
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [GPIO_W-1:0] gpio_in,
	input wire logic timer2_capture,
	input wire logic ext_edge_a_req,
	input wire logic ser_empty_req,
	input wire logic spare_a_req,
	input wire logic spare_b_high,
	input wire logic freq_counter_high
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [5:0] wr_hist;
	// a config write can move the detector input without any pin change
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			wr_hist <= 6'h00;
		else
			wr_hist <= {wr_hist[4:0], psel & penable & pwrite & pready};
	property p_ready;
		psel && !penable |=> pready && penable;
	endproperty
	a_ready: assert property (p_ready) else $error("slave did not answer");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	property p_rsv;
		pready && !pwrite && (paddr == eeif_pkg::ADDR_FLAGS || paddr == eeif_pkg::ADDR_PRIORITY)
			|-> prdata[31:5] == 27'h0;
	endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
	property p_slv;
		pslverr |-> pready && (pwrite || prdata == 32'h0);
	endproperty
	a_slv: assert property (p_slv) else $error("error response malformed");
	property p_cap;
		timer2_capture && wr_hist == 6'h00 |-> $past(gpio_in, 3) != $past(gpio_in, 4)
			|| $past(gpio_in, 2) != $past(gpio_in, 3) || $past(gpio_in, 4) != $past(gpio_in, 5);
	endproperty
	a_cap: assert property (p_cap) else $error("capture without pin edge");
	property p_ser_hold;
		$fell(ser_empty_req) |-> wr_hist[1:0] != 2'h0;
	endproperty
	a_ser_hold: assert property (p_ser_hold) else $error("flag dropped by hw");
	property p_a_rise;
		$rose(ext_edge_a_req) |-> timer2_capture || $past(timer2_capture) || wr_hist[1:0] != 2'h0;
	endproperty
	a_a_rise: assert property (p_a_rise) else $error("edge request w/o event");
	property p_spare;
		$rose(spare_a_req) |-> wr_hist[1:0] != 2'h0;
	endproperty
	a_spare: assert property (p_spare) else $error("spare raised by hw");
	property p_pri;
		$changed(freq_counter_high) || $changed(spare_b_high) |-> wr_hist[1:0] != 2'h0;
	endproperty
	a_pri: assert property (p_pri) else $error("priority moved w/o write");
endmodule
bind eeif_top eeif_top_sva #(.GPIO_W(GPIO_W)) i_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .gpio_in(gpio_in), .timer2_capture(timer2_capture),
	.ext_edge_a_req(ext_edge_a_req), .ser_empty_req(ser_empty_req),
	.spare_a_req(spare_a_req), .spare_b_high(spare_b_high),
	.freq_counter_high(freq_counter_high));

// >>> bench/eeif_far_side.sv
// pins and cpu vectoring seen from outside the block
`timescale 1ns/1ps
module eeif_far_side (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [9:0] pin_want,
	input wire logic req_any,
	output logic [9:0] gpio_in,
	output logic service_enter,
	output logic service_return
);
	logic [1:0] phase;
	always_ff @(posedge pclk)
		gpio_in <= pin_want;
	// cpu vectors and returns but never clears flags itself; latency is tolerated
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			phase <= 2'h0;
		else if (phase != 2'h0 || req_any)
			phase <= phase + 2'h1;
	assign service_enter = (phase == 2'h1);
	assign service_return = (phase == 2'h3);
endmodule

// >>> bench/ext_edge_interrupt_flags_tb.sv
// self-checking bench for the external edge interrupt flag block
`timescale 1ns/1ps
module ext_edge_interrupt_flags_tb;
	logic pclk, presetn, psel, penable, pwrite, ser_holding_empty, pready, pslverr, se, sr;
	logic t2, t3, ar, ah, br, bh, ser_r, sar, sah, sbr, sbh, fh, lvl, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed;
	logic [9:0] pin_want, gpio_in;
	int n_fail, total_checks, p, en, b, n_cap_a, n_cap_b, m_cfg, m_pri, m_ctl;
	eeif_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .gpio_in(gpio_in), .ser_holding_empty(ser_holding_empty),
		.service_enter(se), .service_return(sr), .timer2_capture(t2), .timer3_capture(t3),
		.ext_edge_a_req(ar), .ext_edge_a_high(ah), .ext_edge_b_req(br), .ext_edge_b_high(bh),
		.ser_empty_req(ser_r), .spare_a_req(sar), .spare_a_high(sah), .spare_b_req(sbr),
		.spare_b_high(sbh), .freq_counter_high(fh));
	eeif_far_side i_far (.pclk(pclk), .presetn(presetn), .pin_want(pin_want),
		.req_any(ar | br | ser_r | sar | sbr), .gpio_in(gpio_in), .service_enter(se),
		.service_return(sr));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// a hang here is ended by the watchdog
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		// register model: what software wrote, cut to the stored bits
		if (w && a == eeif_pkg::ADDR_PIN_CONFIG)
			m_cfg = d[7:0];
		else if (w && a == eeif_pkg::ADDR_PRIORITY)
			m_pri = d[7:0] & eeif_pkg::PRI_WRITE_MASK;
		else if (w && a == eeif_pkg::ADDR_CONTROL)
			m_ctl = d[7:0] & eeif_pkg::CTL_WRITE_MASK;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge so the next setup never re-raises psel in this time step
		@(posedge pclk);
	endtask
	// capture strobes last one cycle; count them rather than catch them
	always @(posedge pclk)
	begin
		if (t2 === 1'b1)
			n_cap_a++;
		if (t3 === 1'b1)
			n_cap_b++;
	end
	task automatic rdc(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk("read", rd & msk, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial
	begin
		idle(20000);
		n_fail++;
		final_report();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, ser_holding_empty} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pin_want = 10'h0;
		n_fail = 0;
		total_checks = 0;
		seed = 32'h69BC05B5;
		idle(2);
		presetn <= 1'b1;
		idle(1);
		rdc(eeif_pkg::ADDR_PIN_CONFIG, 32'hFFFFFFFF, 32'h0);
		rdc(eeif_pkg::ADDR_FLAGS, 32'hFFFFFFFF, 32'h0);
		rdc(eeif_pkg::ADDR_PRIORITY, 32'hFFFFFFFF, 32'h0);
		rdc(12'h004, 32'hFFFFFFFF, 32'h0);
		chk("slverr", err, 1'b1);
		// ---------------------------------------------------------------
		// priority levels
		// ---------------------------------------------------------------
		apb(1'b1, eeif_pkg::ADDR_PRIORITY, 32'hFFFFFFFC);
		rdc(eeif_pkg::ADDR_PRIORITY, 32'hFFFFFFFF, 32'h1C);
		idle(2);
		chk("pri", {sbh, sah, fh, ah, bh}, 5'h1C);
		apb(1'b1, eeif_pkg::ADDR_PRIORITY, 32'h08);
		idle(2);
		chk("pri", {sbh, sah, fh}, 3'h2);
		// ---------------------------------------------------------------
		// spare and serializer flags
		// ---------------------------------------------------------------
		apb(1'b1, eeif_pkg::ADDR_CONTROL, 32'h70);
		apb(1'b1, eeif_pkg::ADDR_FLAGS, 32'hFF);
		rdc(eeif_pkg::ADDR_FLAGS, 32'hFFFFFFFF, 32'h18);
		chk("spare", {sar, sbr}, 2'h3);
		ser_holding_empty <= 1'b1;
		idle(3);
		ser_holding_empty <= 1'b0;
		idle(20);
		rdc(eeif_pkg::ADDR_FLAGS, 32'hFF, 32'h1C);
		chk("ser", ser_r, 1'b1);
		apb(1'b1, eeif_pkg::ADDR_FLAGS, 32'h0);
		rdc(eeif_pkg::ADDR_FLAGS, 32'hFF, 32'h0);
		// ---------------------------------------------------------------
		// edge sources over every select code, polarity and mode
		// ---------------------------------------------------------------
		for (int s = 0; s < 2; s++)
			for (int k = 0; k < 32; k++)
			begin
				seed = xs(seed);
				b = k / 16;
				en = seed[31];
				p = (k % 8 == 5) ? 8 + s : k % 8;
				apb(1'b1, eeif_pkg::ADDR_PIN_CONFIG, (k % 16) << (4 * s));
				apb(1'b1, eeif_pkg::ADDR_CONTROL, 3 * b + 12 * en);
				pin_want <= seed[9:0];
				idle(6);
				apb(1'b1, eeif_pkg::ADDR_FLAGS, 32'h0);
				lvl = seed[p] ^ k[3];
				idle(6);
				rdc(eeif_pkg::ADDR_FLAGS, 1 << s, 32'h0);
				pin_want[(p + 1) % 10] <= ~seed[(p + 1) % 10];
				idle(6);
				rdc(eeif_pkg::ADDR_FLAGS, 1 << s, (p + 1) % 10 == p);
				for (int t = 0; t < 2; t++)
				begin
					n_cap_a = 0;
					n_cap_b = 0;
					pin_want[p] <= ~pin_want[p];
					lvl = ~lvl;
					idle(6);
					rdc(eeif_pkg::ADDR_FLAGS, 1 << s, (b || lvl) << s);
					chk("req", s ? br : ar, (b || lvl) && en);
					chk("cap", s ? n_cap_b : n_cap_a, b || lvl);
					apb(1'b1, eeif_pkg::ADDR_FLAGS, 32'h0);
				end
			end
		rdc(eeif_pkg::ADDR_PIN_CONFIG, 32'hFFFFFFFF, 32'hF0);
		rdc(eeif_pkg::ADDR_PIN_CONFIG, 32'hFFFFFFFF, m_cfg);
		rdc(eeif_pkg::ADDR_PRIORITY, 32'hFFFFFFFF, m_pri);
		rdc(eeif_pkg::ADDR_CONTROL, 32'hFFFFFFFF, m_ctl);
		final_report();
	end
endmodule
